//--- verilog/srs_supply_reset_sequencer.sv
`timescale 1ns/1ps
`include "srs_regs.svh"
module srs_supply_reset_sequencer #(
	parameter int EXT_PULSE_CYC = `SRS_CYC(`SRS_EXT_PULSE_NS)
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ioPorOk,
	input wire logic coreBodLow,
	input wire logic monBelow,
	input wire logic watchdogFire,
	input wire logic xtalStable,
	input wire logic [15:0] wakeInputPins,
	input wire logic externalResetPinIn,
	output logic externalResetPinOut,
	output logic externalResetPinOe,
	output logic [2:0] powerSwitchEn,
	output logic regulatorEn,
	output logic sysReset,
	output logic coreReset,
	output logic bodEnable,
	output logic monEnable,
	output logic [3:0] monThreshold,
	output logic rcSlowEn,
	output logic xtalSlowEn,
	output logic slowClkFromXtal,
	output logic fastRcEn,
	output logic [1:0] fastRcFreq,
	output logic masterClockFromFastRc,
	output srs_pkg::srs_cause_t resetCause,
	output logic irq
);
	import srs_pkg::*;

	localparam logic [15:0] SW_STEP_CYC = 16'(`SRS_CYC(`SRS_SW_STEP_NS));
	localparam logic [15:0] REG_CYC = 16'(`SRS_CYC(`SRS_REG_SETTLE_NS));
	localparam logic [15:0] SYS_REL_CYC = 16'(`SRS_CYC(`SRS_SYS_REL_NS));
	localparam logic [15:0] CORE_REL_CYC = 16'(`SRS_CYC(`SRS_CORE_REL_NS));
	localparam logic [31:0] EXT_CYC = 32'(EXT_PULSE_CYC);

	srs_async_t syncA_reg, syncB_reg;
	srs_mode_t mode_reg;
	srs_state_t state_reg, state_next;
	srs_cause_t cause_reg, pendCause_reg, pendCause_next;
	logic [15:0] wakeEn_reg;
	logic [`SRS_EV_W-1:0] event_reg, mask_reg, eventSet;
	logic [15:0] seqCnt_reg;
	logic [1:0] swStep_reg;
	logic [31:0] extCnt_reg;
	logic [1:0] guard_reg;
	logic [`SRS_DIV_W-1:0] divCnt_reg;
	logic monOn_reg, slowXtal_reg;
	logic [31:0] prdata_reg, rdMux;
	logic pready_reg, pslverr_reg, irq_reg;
	logic [2:0] sw_reg;
	logic regEn_reg, sysRst_reg, coreRst_reg, frcMck_reg, extOe_reg;

	// 2-flop synchronisers for all pin and analog inputs
	always_ff @(posedge core_clk)
	begin
		syncA_reg <= {wakeInputPins, xtalStable, watchdogFire, externalResetPinIn, monBelow,
			coreBodLow, ioPorOk};
		syncB_reg <= syncA_reg;
	end

	// apb decode
	wire apbAccess = psel && penable && !pready_reg;
	wire apbDone = psel && penable && pready_reg;
	wire apbWr = apbDone && pwrite;
	wire apbRdEvent = apbDone && !pwrite && paddr == `SRS_OFF_EVENT;
	wire hitMode = paddr == `SRS_OFF_MODE;
	wire hitStatus = paddr == `SRS_OFF_STATUS;
	wire hitEvent = paddr == `SRS_OFF_EVENT;
	wire hitMask = paddr == `SRS_OFF_MASK;
	wire hitWake = paddr == `SRS_OFF_WAKE;
	wire hitAny = hitMode || hitStatus || hitEvent || hitMask || hitWake;
	wire [31:0] statusWord = {16'h0000, 2'h0, state_reg, slowXtal_reg, monOn_reg,
		syncB_reg.resetPinIn, cause_reg, 2'h0};
	assign rdMux = hitMode ? {19'h00000, mode_reg} :
		hitStatus ? statusWord :
		hitEvent ? {27'h0000000, event_reg} :
		hitMask ? {27'h0000000, mask_reg} :
		hitWake ? {16'h0000, wakeEn_reg} : 32'h00000000;

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
		end
		else
		begin
			pready_reg <= apbAccess;
			pslverr_reg <= apbAccess && !hitAny;
			prdata_reg <= (apbAccess && !pwrite) ? rdMux : 32'h00000000;
		end
	end

	// reset sources; cause priority is por, watchdog, brownout, software, user
	wire porLow = !syncB_reg.ioPorOk;
	wire bodTrip = !mode_reg.bodDis && syncB_reg.coreBodLow;
	wire wdTrip = syncB_reg.watchdogFire;
	wire softReq = apbWr && hitMode && pwdata[`SRS_MODE_SOFTRST];
	wire sleepReq = apbWr && hitMode && pwdata[`SRS_MODE_SLEEP];
	wire userPress = !syncB_reg.resetPinIn && !externalResetPinOe && guard_reg == 2'h0;
	wire [15:0] fastStartup = syncB_reg.wakePins & wakeEn_reg;
	wire wakeReq = |fastStartup;
	wire running = state_reg == SRS_RUN;
	wire coreRstReq = running && (wdTrip || bodTrip || softReq || userPress);
	wire coreRelease = state_reg == SRS_CORE && seqCnt_reg == CORE_REL_CYC;
	wire monTrip = monOn_reg && syncB_reg.monBelow;

	// sequencer
	always_comb
	begin
		state_next = state_reg;
		pendCause_next = pendCause_reg;
		case (state_reg)
			SRS_OFF:
				if (!porLow)
					state_next = SRS_SWITCH;
			SRS_SWITCH:
				if (seqCnt_reg == SW_STEP_CYC && swStep_reg == 2'(`SRS_NUM_SWITCH - 1))
					state_next = SRS_REGUL;
			SRS_REGUL:
				if (seqCnt_reg == REG_CYC)
					state_next = SRS_CORE;
			SRS_CORE:
				if (coreRelease)
					state_next = SRS_RUN;
			SRS_RUN:
				if (coreRstReq)
				begin
					state_next = SRS_CORE;
					pendCause_next = wdTrip ? SRS_CAUSE_WATCHDOG :
						bodTrip ? SRS_CAUSE_GENERAL :
						softReq ? SRS_CAUSE_SOFTWARE : SRS_CAUSE_USER;
				end
				else if (sleepReq)
					state_next = SRS_SLEEP;
			SRS_SLEEP:
				if (wakeReq)
				begin
					state_next = SRS_SWITCH;
					pendCause_next = SRS_CAUSE_WAKEUP;
				end
			default:
				state_next = SRS_OFF;
		endcase
		if (porLow)
		begin
			state_next = SRS_OFF;
			pendCause_next = SRS_CAUSE_GENERAL;
		end
	end

	// the manager's own reset is rst, kept apart from the core resets it drives
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			state_reg <= SRS_OFF;
			pendCause_reg <= SRS_CAUSE_GENERAL;
			cause_reg <= SRS_CAUSE_GENERAL;
			seqCnt_reg <= 16'h0000;
			swStep_reg <= 2'h0;
		end
		else
		begin
			state_reg <= state_next;
			pendCause_reg <= pendCause_next;
			if (coreRelease)
				cause_reg <= pendCause_reg;
			if (state_next != state_reg)
			begin
				seqCnt_reg <= 16'h0000;
				swStep_reg <= 2'h0;
			end
			else if ((state_reg == SRS_SWITCH) && seqCnt_reg == SW_STEP_CYC)
			begin
				seqCnt_reg <= 16'h0000;
				swStep_reg <= swStep_reg + 2'h1;
			end
			else if (state_reg != SRS_RUN && state_reg != SRS_SLEEP && state_reg != SRS_OFF)
				seqCnt_reg <= seqCnt_reg + 16'h0001;
		end
	end

	// power outputs follow the sequence, one switch per step
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			sw_reg <= 3'h0;
			regEn_reg <= 1'b0;
			sysRst_reg <= 1'b1;
			coreRst_reg <= 1'b1;
			frcMck_reg <= 1'b0;
		end
		else
		begin
			if (state_next == SRS_OFF || state_next == SRS_SLEEP)
				sw_reg <= 3'h0;
			else if (state_reg == SRS_SWITCH)
				sw_reg[swStep_reg] <= 1'b1;
			regEn_reg <= state_next == SRS_CORE || state_next == SRS_RUN;
			sysRst_reg <= !(state_next == SRS_RUN ||
				(state_reg == SRS_CORE && seqCnt_reg >= SYS_REL_CYC));
			coreRst_reg <= state_next != SRS_RUN;
			frcMck_reg <= state_next == SRS_RUN;
		end
	end

	wire extLoad = coreRstReq || porLow || (state_reg == SRS_SLEEP && wakeReq);
	// reset pin: open-drain pulse out, push-button in, short guard after the drive ends
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			extCnt_reg <= 32'h00000000;
			extOe_reg <= 1'b0;
			guard_reg <= `SRS_PIN_GUARD;
		end
		else
		begin
			// enable is the registered image of a nonzero next count
			extOe_reg <= extLoad || extCnt_reg > 32'h00000001;
			if (extLoad)
				extCnt_reg <= EXT_CYC;
			else if (extCnt_reg != 32'h00000000)
				extCnt_reg <= extCnt_reg - 32'h00000001;
			if (externalResetPinOe)
				guard_reg <= `SRS_PIN_GUARD; // the pin synchroniser lags the release
			else if (guard_reg != 2'h0)
				guard_reg <= guard_reg - 2'h1;
		end
	end

	// configuration; por wipes it because the i/o domain itself lost power
	always_ff @(posedge core_clk)
	begin
		if (rst || porLow)
		begin
			mode_reg <= srs_mode_t'(`SRS_MODE_RST);
			mask_reg <= 5'h00;
			wakeEn_reg <= 16'h0000;
			slowXtal_reg <= 1'b0;
		end
		else
		begin
			if (apbWr && hitMode)
				mode_reg <= srs_mode_t'(pwdata[`SRS_MODE_W-1:0]);
			if (apbWr && hitMask)
				mask_reg <= pwdata[`SRS_EV_W-1:0];
			if (apbWr && hitWake)
				wakeEn_reg <= pwdata[15:0];
			// switch only once the crystal reports stable
			slowXtal_reg <= mode_reg.slowXtalSel && mode_reg.xtalEn && syncB_reg.xtalStable;
		end
	end

	// sampled supply monitor
	wire [3:0] divSel = (mode_reg.sampleDiv > `SRS_DIV_MAX) ? `SRS_DIV_MAX : mode_reg.sampleDiv;
	wire [`SRS_DIV_W-1:0] divTop = `SRS_DIV_W'((32'h1 << divSel) - 32'h1);
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			divCnt_reg <= `SRS_DIV_W'h0;
			monOn_reg <= 1'b0;
		end
		else
		begin
			divCnt_reg <= (divCnt_reg >= divTop) ? `SRS_DIV_W'h0 : divCnt_reg + `SRS_DIV_W'h1;
			monOn_reg <= mode_reg.monEn && (!mode_reg.sampleMode || divCnt_reg == `SRS_DIV_W'h0);
		end
	end

	// sticky events, cleared by reading; a new event wins over the clear
	always_comb
	begin
		eventSet = 5'h00;
		eventSet[`SRS_EV_MON] = monTrip;
		eventSet[`SRS_EV_BOD] = running && bodTrip;
		eventSet[`SRS_EV_USER] = running && userPress;
		eventSet[`SRS_EV_WAKE] = state_reg == SRS_SLEEP && wakeReq;
		eventSet[`SRS_EV_WDOG] = running && wdTrip;
	end
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			event_reg <= 5'h00;
			irq_reg <= 1'b0;
		end
		else
		begin
			event_reg <= (apbRdEvent ? 5'h00 : event_reg) | eventSet;
			irq_reg <= |(((apbRdEvent ? 5'h00 : event_reg) | eventSet) & mask_reg);
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign externalResetPinOut = 1'b0;
	assign externalResetPinOe = extOe_reg;
	assign powerSwitchEn = sw_reg;
	assign regulatorEn = regEn_reg;
	assign sysReset = sysRst_reg;
	assign coreReset = coreRst_reg;
	assign bodEnable = !mode_reg.bodDis;
	assign monEnable = monOn_reg;
	assign monThreshold = mode_reg.monThresh;
	assign rcSlowEn = !slowXtal_reg;
	assign xtalSlowEn = mode_reg.xtalEn;
	assign slowClkFromXtal = slowXtal_reg;
	assign fastRcEn = 1'b1;
	assign fastRcFreq = `SRS_FRC_4MHZ;
	assign masterClockFromFastRc = frcMck_reg;
	assign resetCause = cause_reg;
	assign irq = irq_reg;

	a_por_reset: assert property (@(posedge core_clk) disable iff (rst)
		porLow |=> state_reg == SRS_OFF ##1 coreReset && powerSwitchEn == 3'h0)
		else $error("power-on-reset did not reset the chip");
	a_bod_core: assert property (@(posedge core_clk) disable iff (rst)
		running && bodTrip && !porLow |=> coreReset)
		else $error("brownout did not assert core reset");
	a_bod_enable: assert property (@(posedge core_clk) disable iff (rst)
		$past(porLow) |-> bodEnable)
		else $error("brownout detector not enabled after por");
	a_mon_sample: assert property (@(posedge core_clk) disable iff (rst)
		monEnable && mode_reg.sampleMode && divTop != 11'h0 && $stable(mode_reg) |=> !monEnable)
		else $error("sampled monitor on for two cycles");
	a_cause_hold: assert property (@(posedge core_clk) disable iff (rst)
		!$past(coreRelease) |-> $stable(cause_reg))
		else $error("reset cause changed outside a release");
	a_pin_pulse: assert property (@(posedge core_clk) disable iff (rst)
		coreRstReq && !porLow |=> externalResetPinOe [*8])
		else $error("reset pin pulse too short");
	a_order_rel: assert property (@(posedge core_clk) disable iff (rst)
		$fell(coreReset) |-> !sysReset && regulatorEn && powerSwitchEn == 3'h7)
		else $error("core released out of order");
	a_slow_excl: assert property (@(posedge core_clk) disable iff (rst)
		slowClkFromXtal |-> $past(xtalSlowEn) && !rcSlowEn)
		else $error("selected slow oscillator off or both on");
	a_wake_seq: assert property (@(posedge core_clk) disable iff (rst)
		state_reg == SRS_SLEEP && wakeReq && !porLow |=> state_reg == SRS_SWITCH ##1
		powerSwitchEn == 3'h1)
		else $error("wake did not rerun power sequence");
	a_mck_start: assert property (@(posedge core_clk) disable iff (rst)
		$fell(coreReset) |-> masterClockFromFastRc && fastRcFreq == `SRS_FRC_4MHZ)
		else $error("master clock not on fast rc at startup");
endmodule // srs_supply_reset_sequencer

//--- verilog/srs_regs.svh
`ifndef SRS_REGS_SVH
`define SRS_REGS_SVH
// apb byte offsets
`define SRS_OFF_MODE 8'h00
`define SRS_OFF_STATUS 8'h04
`define SRS_OFF_EVENT 8'h08
`define SRS_OFF_MASK 8'h0c
`define SRS_OFF_WAKE 8'h10
// mode register fields
`define SRS_MODE_W 13
`define SRS_MODE_RST 13'h0000
`define SRS_MODE_SOFTRST 16
`define SRS_MODE_SLEEP 17
// event bits
`define SRS_EV_W 5
`define SRS_EV_MON 0
`define SRS_EV_BOD 1
`define SRS_EV_USER 2
`define SRS_EV_WAKE 3
`define SRS_EV_WDOG 4
// sampled monitor: divider exponent tops out at 2**11 = 2048
`define SRS_DIV_MAX 4'hb
`define SRS_DIV_W 11
// fast rc frequency code for 4 mhz
`define SRS_FRC_4MHZ 2'h0
// timing: clock rate and times in ns, cycles rounded up
`define SRS_CLK_MHZ 25
`define SRS_CYC(ns) ((((ns) * `SRS_CLK_MHZ) + 999) / 1000)
`define SRS_SW_STEP_NS 2000
`define SRS_REG_SETTLE_NS 20000
`define SRS_SYS_REL_NS 4000
`define SRS_CORE_REL_NS 8000
`define SRS_EXT_PULSE_NS 1000000
`define SRS_NUM_SWITCH 3
`define SRS_PIN_GUARD 2'h3
`endif

//--- verilog/srs_pkg.sv
package srs_pkg;
	typedef enum logic [5:0] {
		SRS_OFF = 6'h01,
		SRS_SWITCH = 6'h02,
		SRS_REGUL = 6'h04,
		SRS_CORE = 6'h08,
		SRS_RUN = 6'h10,
		SRS_SLEEP = 6'h20
	} srs_state_t;
	typedef enum logic [2:0] {
		SRS_CAUSE_GENERAL = 3'h0,
		SRS_CAUSE_WAKEUP = 3'h1,
		SRS_CAUSE_SOFTWARE = 3'h2,
		SRS_CAUSE_USER = 3'h3,
		SRS_CAUSE_WATCHDOG = 3'h4
	} srs_cause_t;
	typedef struct packed {
		logic [3:0] sampleDiv;
		logic sampleMode;
		logic [3:0] monThresh;
		logic monEn;
		logic slowXtalSel;
		logic xtalEn;
		logic bodDis;
	} srs_mode_t;
	typedef struct packed {
		logic [15:0] wakePins;
		logic xtalStable;
		logic watchdogFire;
		logic resetPinIn;
		logic monBelow;
		logic coreBodLow;
		logic ioPorOk;
	} srs_async_t;
endpackage

//--- tb/srs_pin_partner.sv
`timescale 1ns/1ps
module srs_pin_partner (
	input wire logic core_clk,
	input wire logic pinOe,
	input wire logic pinOut,
	input wire logic pressReq,
	output logic pinLevel
);
	logic pressReg = 1'b0;
	// a contact closes on the rising edge after the request, the same edge the block samples on
	always_ff @(posedge core_clk)
	begin
		pressReg <= pressReq;
	end
	// pull-up line: low while the block pulls it or the button shorts it
	assign pinLevel = ((pinOe && !pinOut) || pressReg) ? 1'b0 : 1'b1;
endmodule // srs_pin_partner

//--- tb/tb_top.sv
`timescale 1ns/1ps
`include "srs_regs.svh"
module tb_top;
	import srs_pkg::*;
	typedef struct {logic [31:0] data; logic [31:0] mask; logic err;} srs_exp_t;
	logic core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, modeVal;
	logic pready, pslverr, irq, pinLevel, pinOut, pinOe, pressReq = 1'b0;
	logic ioPorOk = 1'b1, coreBodLow = 1'b0, monBelow = 1'b0, watchdogFire = 1'b0;
	logic xtalStable = 1'b1, regulatorEn, sysReset, coreReset, bodEnable, monEnable;
	logic [15:0] wakeInputPins = 16'h0;
	logic [2:0] powerSwitchEn;
	logic [3:0] monThreshold, thr;
	logic rcSlowEn, xtalSlowEn, slowClkFromXtal, fastRcEn, masterClockFromFastRc;
	logic [1:0] fastRcFreq;
	logic regPrev = 1'b0, corePrev = 1'b1, sawOe = 1'b0;
	srs_cause_t resetCause;
	srs_exp_t expQ[$];
	int n_errors = 0, n_compared = 0, wk, cnt;
	srs_cause_t causes[3] = '{SRS_CAUSE_SOFTWARE, SRS_CAUSE_WATCHDOG, SRS_CAUSE_USER};

	srs_supply_reset_sequencer #(.EXT_PULSE_CYC(16)) srs_supply_reset_sequencer_inst (
		.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ioPorOk(ioPorOk), .coreBodLow(coreBodLow), .monBelow(monBelow),
		.watchdogFire(watchdogFire), .xtalStable(xtalStable), .wakeInputPins(wakeInputPins),
		.externalResetPinIn(pinLevel), .externalResetPinOut(pinOut),
		.externalResetPinOe(pinOe), .powerSwitchEn(powerSwitchEn), .regulatorEn(regulatorEn),
		.sysReset(sysReset), .coreReset(coreReset), .bodEnable(bodEnable),
		.monEnable(monEnable), .monThreshold(monThreshold), .rcSlowEn(rcSlowEn),
		.xtalSlowEn(xtalSlowEn), .slowClkFromXtal(slowClkFromXtal), .fastRcEn(fastRcEn),
		.fastRcFreq(fastRcFreq), .masterClockFromFastRc(masterClockFromFastRc),
		.resetCause(resetCause), .irq(irq));
	srs_pin_partner srs_pin_partner_inst (.core_clk(core_clk), .pinOe(pinOe),
		.pinOut(pinOut), .pressReq(pressReq), .pinLevel(pinLevel));

	initial
	begin
		forever #20 core_clk = ~core_clk;
	end

	task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] got);
		n_compared++;
		if (got !== e)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, e, got);
		end
	endtask

	task automatic tally_and_finish();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// the request is held until pready is seen, then released with one idle edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] e, input logic [31:0] m, input logic err);
		int n;
		expQ.push_back('{e, m, err});
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		// look at pready where it is settled, then release after the edge that samples it
		do
		begin
			@(negedge core_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			n_errors++;
		@(posedge core_clk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	// waits for the core to enter reset, drops the stimulus, then waits for run
	task automatic rerun();
		int n;
		n = 0;
		while (coreReset !== 1'b1 && n < 300)
		begin
			@(posedge core_clk);
			n++;
		end
		watchdogFire <= 1'b0;
		pressReq <= 1'b0;
		coreBodLow <= 1'b0;
		while (!(masterClockFromFastRc === 1'b1 && coreReset === 1'b0) && n < 3000)
		begin
			@(posedge core_clk);
			n++;
		end
		cmp("run reached", 32'h1, {31'h0, masterClockFromFastRc & ~coreReset});
	endtask

	task automatic cause_is(input srs_cause_t c);
		apb(1'b0, `SRS_OFF_STATUS, 32'h0, 32'(c) << 2, 32'h1c, 1'b0);
	endtask

	// outputs change on the rising edge, so the watcher samples them half a period later
	always @(negedge core_clk)
	begin
		if (pready === 1'b1)
		begin
			if (expQ.size() == 0)
				cmp("unexpected pready", 32'h0, 32'h1);
			else
			begin
				cmp("prdata", expQ[0].data & expQ[0].mask, prdata & expQ[0].mask);
				cmp("pslverr", {31'h0, expQ[0].err}, {31'h0, pslverr});
				void'(expQ.pop_front());
			end
		end
		if (!rst && regulatorEn === 1'b1 && !regPrev)
			cmp("switches at regulator on", 32'h7, {29'h0, powerSwitchEn});
		if (!rst && coreReset === 1'b0 && corePrev)
		begin
			cmp("regulator at core release", 32'h1, {31'h0, regulatorEn});
			cmp("system before core", 32'h0, {31'h0, sysReset});
		end
		regPrev = regulatorEn;
		corePrev = coreReset;
		if (pinOe === 1'b1)
			sawOe = 1'b1;
	end

	initial
	begin
		repeat (60000) @(posedge core_clk);
		n_errors++;
		tally_and_finish();
	end

	initial
	begin
		void'($urandom(59));
		thr = 4'($urandom % 16);
		wk = $urandom % 16;
		cycles(5);
		rst <= 1'b0;
		rerun();
		cmp("bod on", 32'h1, {31'h0, bodEnable});
		cmp("monitor off", 32'h0, {31'h0, monEnable});
		cmp("slow rc", 32'h2, {30'h0, rcSlowEn, slowClkFromXtal});
		cmp("xtal off", 32'h0, {31'h0, xtalSlowEn});
		cmp("fast rc 4mhz", 32'h4, {29'h0, fastRcEn, fastRcFreq});
		apb(1'b0, `SRS_OFF_MODE, 32'h0, 32'h0, 32'hffffffff, 1'b0);
		cause_is(SRS_CAUSE_GENERAL);
		apb(1'b0, 8'h14, 32'h0, 32'h0, 32'hffffffff, 1'b1);
		modeVal = 32'h1700 | (32'(thr) << 4) | 32'he;
		apb(1'b1, `SRS_OFF_MODE, modeVal, 32'h0, 32'h0, 1'b0);
		apb(1'b1, `SRS_OFF_MASK, 32'h4, 32'h0, 32'h0, 1'b0);
		cycles(6);
		cmp("threshold", 32'(thr), 32'(monThreshold));
		cmp("xtal chosen", 32'h1, {30'h0, rcSlowEn, slowClkFromXtal});
		cnt = 0;
		monBelow <= 1'b1;
		repeat (4096)
		begin
			@(posedge core_clk);
			cnt += (monEnable === 1'b1);
		end
		monBelow <= 1'b0;
		cmp("sampled strobes", 32'h1, {31'h0, cnt >= 1 && cnt <= 3});
		apb(1'b0, `SRS_OFF_EVENT, 32'h0, 32'h1, 32'h1, 1'b0);
		foreach (causes[k])
		begin
			sawOe = 1'b0;
			if (k == 0)
				apb(1'b1, `SRS_OFF_MODE, modeVal | 32'h10000, 32'h0, 32'h0, 1'b0);
			else if (k == 1)
				watchdogFire <= 1'b1;
			else
				pressReq <= 1'b1;
			rerun();
			cmp("pin pulse", 32'h1, {31'h0, sawOe & ~pinOut});
			cause_is(causes[k]);
		end
		cmp("irq user", 32'h1, {31'h0, irq});
		apb(1'b0, `SRS_OFF_EVENT, 32'h0, 32'h4, 32'h4, 1'b0);
		cycles(2);
		cmp("irq cleared", 32'h0, {31'h0, irq});
		apb(1'b0, `SRS_OFF_MODE, 32'h0, modeVal, 32'hffffffff, 1'b0);
		apb(1'b1, `SRS_OFF_MODE, modeVal | 32'h1, 32'h0, 32'h0, 1'b0);
		coreBodLow <= 1'b1;
		cycles(20);
		cmp("bod disabled", 32'h0, {bodEnable, coreReset});
		coreBodLow <= 1'b0;
		apb(1'b1, `SRS_OFF_MODE, modeVal, 32'h0, 32'h0, 1'b0);
		coreBodLow <= 1'b1;
		rerun();
		cause_is(SRS_CAUSE_GENERAL);
		apb(1'b1, `SRS_OFF_WAKE, 32'h1 << wk, 32'h0, 32'h0, 1'b0);
		apb(1'b1, `SRS_OFF_MODE, modeVal | 32'h20000, 32'h0, 32'h0, 1'b0);
		cnt = 0;
		while (regulatorEn !== 1'b0 && cnt < 200)
		begin
			@(posedge core_clk);
			cnt++;
		end
		cycles(3);
		cmp("sleep power off", 32'h0, {powerSwitchEn, regulatorEn});
		wakeInputPins <= 16'h1 << wk;
		rerun();
		wakeInputPins <= 16'h0;
		cause_is(SRS_CAUSE_WAKEUP);
		ioPorOk <= 1'b0;
		cycles(4);
		cmp("por reset", 32'h3, {sysReset, coreReset});
		ioPorOk <= 1'b1;
		rerun();
		apb(1'b0, `SRS_OFF_MODE, 32'h0, 32'h0, 32'hffffffff, 1'b0);
		tally_and_finish();
	end
endmodule // tb_top
